// ==== asd_pkg.sv ====
// Constants, types and register map of the shift and overflow datapath
// Function
// - The output shifter moves the 32-bit accumulator left by 0 to 7 bits.
// - The store picks the high or low 16-bit half of the shifted value.
// - Overflow flag is bit 12 of status word A, set on accumulator overflow.
// - With saturation on, overflow loads the most positive or negative value.
// - Saturation enable is bit 11 of status word A.
// - The 32-bit product register holds a result until the next multiply.
// - The product shifter passes, shifts left 1 or 4, or right 6 the product.
// - The product shift select field is bits 1:0 of status word B.
// - Sign extend enable is bit 10 of status word B, for the input shifter.
// - Sign extend enable makes accumulator shifts arithmetic, else logical.
// - Sign extension fills all unused upper bits with the operand's MSB.
// - Both status words are 16 bits and fully savable and reloadable.
// - An accumulator add result too large for 32 bits is flagged as overflow.
// - The multiplier forms a 32-bit product of two 16-bit operands.
// - The input shifter places 16-bit data shifted left 0 to 16 places.
package asd_pkg;
    // ********************************
    // Register offsets (byte addresses)
    // ********************************
    localparam logic [5:0] ASD_OFS_STA = 6'h00;
    localparam logic [5:0] ASD_OFS_STB = 6'h04;
    localparam logic [5:0] ASD_OFS_MULS = 6'h08;
    localparam logic [5:0] ASD_OFS_MULU = 6'h0c;
    localparam logic [5:0] ASD_OFS_PRODUCT_RESULT_REGISTER = 6'h10;
    localparam logic [5:0] ASD_OFS_PSH = 6'h14;
    localparam logic [5:0] ASD_OFS_ACC = 6'h18;
    localparam logic [5:0] ASD_OFS_ADDIN = 6'h1c;
    localparam logic [5:0] ASD_OFS_ADDP = 6'h20;
    localparam logic [5:0] ASD_OFS_STORE = 6'h24;
    localparam logic [5:0] ASD_OFS_ASH = 6'h28;
    // ********************************
    // Field positions
    // ********************************
    localparam int ASD_OVF_BIT = 12;
    localparam int ASD_SAT_BIT = 11;
    localparam int ASD_SXM_BIT = 10;
    localparam int ASD_PM_LO = 0;
    localparam int ASD_INSH_LO = 16;
    localparam int ASD_HISEL_BIT = 3;
    // ********************************
    // Reset values and constants
    // ********************************
    localparam logic [15:0] ASD_STA_RST = 16'h0000;
    localparam logic [15:0] ASD_STB_RST = 16'h0400;
    localparam logic [31:0] ASD_ACC_MAX = 32'h7fffffff;
    localparam logic [31:0] ASD_ACC_MIN = 32'h80000000;
    localparam logic [4:0] ASD_INSH_MAX = 5'h10;
    // ********************************
    // Types
    // ********************************
    typedef enum logic [1:0] {
        ASD_PM_NONE = 2'b00,
        ASD_PM_L1 = 2'b01,
        ASD_PM_L4 = 2'b10,
        ASD_PM_R6 = 2'b11
    } asd_pm_t;
    typedef enum logic {
        ASD_IDLE = 1'b0,
        ASD_ACK = 1'b1
    } asd_bus_st_t;
    typedef struct packed {
        logic ovf;
        logic [31:0] val;
    } asd_sum_t;
endpackage

// ==== asd_datapath.sv ====
// Accumulator, product and output shifters with overflow handling
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module asd_datapath
    import asd_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic [5:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    output logic [15:0] data_write_bus_o
);
    // ********************************
    // State
    // ********************************
    asd_bus_st_t bus_st;
    logic [15:0] status_word_a;
    logic [15:0] status_word_b;
    logic [31:0] product_result_register;
    logic [31:0] acc;
    logic sat_en;
    logic sign_extend_enable;
    asd_pm_t pm;
    logic go;
    logic wr;
    logic [31:0] pshift;
    logic [31:0] in_ext;
    logic [31:0] in_sh;
    logic [4:0] in_cnt;
    logic [31:0] out_sh;
    logic [31:0] addend;
    logic add_ev;
    asd_sum_t sum;
    logic [31:0] acc_shifted;
    logic [31:0] rd_mux;

    assign sat_en = status_word_a[ASD_SAT_BIT];
    assign sign_extend_enable = status_word_b[ASD_SXM_BIT];
    assign pm = asd_pm_t'(status_word_b[ASD_PM_LO +: 2]);
    assign go = ce_i & (read_i | write_i) & (bus_st == ASD_IDLE);
    assign wr = go & write_i;

    // ********************************
    // Bus handshake
    // ********************************
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            bus_st <= ASD_IDLE;
            waitrequest_o <= 1'b1;
        end
        else if (ce_i)
        begin
            case (bus_st)
                ASD_IDLE:
                begin
                    if (read_i | write_i)
                    begin
                        bus_st <= ASD_ACK;
                        waitrequest_o <= 1'b0;
                    end
                end
                ASD_ACK:
                begin
                    bus_st <= ASD_IDLE;
                    waitrequest_o <= 1'b1;
                end
                default:
                begin
                    bus_st <= ASD_IDLE;
                    waitrequest_o <= 1'b1;
                end
            endcase
        end
    end

    // ********************************
    // Product shifter
    // ********************************
    always_comb
    begin
        case (pm)
            ASD_PM_NONE: pshift = product_result_register;
            ASD_PM_L1: pshift = {product_result_register[30:0], 1'b0};
            ASD_PM_L4: pshift = {product_result_register[27:0], 4'h0};
            ASD_PM_R6: pshift = 32'($signed(product_result_register) >>> 6);
            default: pshift = product_result_register;
        endcase
    end

    // ********************************
    // Input shifter
    // ********************************
    always_comb
    begin
        in_cnt = writedata_i[ASD_INSH_LO +: 5];
        if (in_cnt > ASD_INSH_MAX)
        begin
            in_cnt = ASD_INSH_MAX;
        end
        in_ext = {{16{sign_extend_enable & writedata_i[15]}}, writedata_i[15:0]};
        in_sh = in_ext << in_cnt;
    end

    // ********************************
    // Accumulator adder with overflow
    // ********************************
    assign addend = (address_i == ASD_OFS_ADDP) ? pshift : in_sh;
    assign add_ev = wr & ((address_i == ASD_OFS_ADDP) |
        (address_i == ASD_OFS_ADDIN));

    always_comb
    begin
        sum.val = acc + addend;
        sum.ovf = (acc[31] == addend[31]) & (sum.val[31] != acc[31]);
    end

    // ********************************
    // Accumulator one-bit shifts
    // ********************************
    always_comb
    begin
        if (writedata_i[0])
        begin
            acc_shifted = {sign_extend_enable & acc[31], acc[31:1]};
        end
        else
        begin
            acc_shifted = {acc[30:0], 1'b0};
        end
    end

    // ********************************
    // Output shifter
    // ********************************
    assign out_sh = acc << writedata_i[2:0];

    // ********************************
    // Accumulator
    // ********************************
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            acc <= '0;
        end
        else if (add_ev)
        begin
            if (sum.ovf & sat_en)
            begin
                acc <= acc[31] ? ASD_ACC_MIN : ASD_ACC_MAX;
            end
            else
            begin
                acc <= sum.val;
            end
        end
        else if (wr & (address_i == ASD_OFS_ACC))
        begin
            acc <= writedata_i;
        end
        else if (wr & (address_i == ASD_OFS_ASH))
        begin
            acc <= acc_shifted;
        end
    end

    // ********************************
    // Status words
    // ********************************
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            status_word_a <= ASD_STA_RST;
        end
        else if (ce_i)
        begin
            if (wr & (address_i == ASD_OFS_STA))
            begin
                status_word_a <= writedata_i[15:0];
            end
            if (add_ev & sum.ovf)
            begin
                status_word_a[ASD_OVF_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            status_word_b <= ASD_STB_RST;
        end
        else if (wr & (address_i == ASD_OFS_STB))
        begin
            status_word_b <= writedata_i[15:0];
        end
    end

    // ********************************
    // Multiplier and product register
    // ********************************
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            product_result_register <= '0;
        end
        else if (wr & (address_i == ASD_OFS_MULS))
        begin
            product_result_register <= 32'($signed(writedata_i[15:0]) *
                $signed(writedata_i[31:16]));
        end
        else if (wr & (address_i == ASD_OFS_MULU))
        begin
            product_result_register <= writedata_i[15:0] *
                writedata_i[31:16];
        end
    end

    // ********************************
    // Store to data write bus
    // ********************************
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            data_write_bus_o <= '0;
        end
        else if (wr & (address_i == ASD_OFS_STORE))
        begin
            data_write_bus_o <= writedata_i[ASD_HISEL_BIT] ?
                out_sh[31:16] : out_sh[15:0];
        end
    end

    // ********************************
    // Read data
    // ********************************
    always_comb
    begin
        case (address_i)
            ASD_OFS_STA: rd_mux = {16'h0000, status_word_a};
            ASD_OFS_STB: rd_mux = {16'h0000, status_word_b};
            ASD_OFS_PRODUCT_RESULT_REGISTER: rd_mux = product_result_register;
            ASD_OFS_PSH: rd_mux = pshift;
            ASD_OFS_ACC: rd_mux = acc;
            ASD_OFS_STORE: rd_mux = {16'h0000, data_write_bus_o};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            readdata_o <= '0;
        end
        else if (go & read_i)
        begin
            readdata_o <= rd_mux;
        end
    end

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    property p_ovf_set;
        add_ev & sum.ovf |=> status_word_a[ASD_OVF_BIT];
    endproperty
    a_ovf_set: assert property (p_ovf_set)
        else $error("overflow flag not set");

    property p_sat_pos;
        add_ev & sum.ovf & sat_en & !acc[31] |=> acc == ASD_ACC_MAX;
    endproperty
    a_sat_pos: assert property (p_sat_pos)
        else $error("positive saturation wrong");

    property p_sat_neg;
        add_ev & sum.ovf & sat_en & acc[31] |=> acc == ASD_ACC_MIN;
    endproperty
    a_sat_neg: assert property (p_sat_neg)
        else $error("negative saturation wrong");

    property p_wrap;
        add_ev & !sat_en |=> acc == $past(sum.val);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("unsaturated sum wrong");

    property p_product_result_register_hold;
        !(wr & (address_i == ASD_OFS_MULS | address_i == ASD_OFS_MULU))
            |=> $stable(product_result_register);
    endproperty
    a_product_result_register_hold: assert property (p_product_result_register_hold)
        else $error("product register changed");

    property p_mul_s;
        wr & (address_i == ASD_OFS_MULS) |=> product_result_register ==
            32'($signed($past(writedata_i[15:0])) *
            $signed($past(writedata_i[31:16])));
    endproperty
    a_mul_s: assert property (p_mul_s)
        else $error("signed product wrong");

    property p_pm_r6;
        (pm == ASD_PM_R6) |-> pshift[31:26] == {6{pshift[25]}};
    endproperty
    a_pm_r6: assert property (p_pm_r6)
        else $error("right six shift not sign filled");

    property p_store;
        wr & (address_i == ASD_OFS_STORE) & !writedata_i[ASD_HISEL_BIT]
            |=> data_write_bus_o == $past(out_sh[15:0]);
    endproperty
    a_store: assert property (p_store)
        else $error("low half store wrong");

    property p_lshr;
        wr & (address_i == ASD_OFS_ASH) & writedata_i[0] & !sign_extend_enable
            |=> !acc[31];
    endproperty
    a_lshr: assert property (p_lshr)
        else $error("logical shift kept sign");

    property p_wait;
        go |=> !waitrequest_o ##1 waitrequest_o;
    endproperty
    a_wait: assert property (p_wait)
        else $error("waitrequest sequence wrong");

    c_ovf: cover property (add_ev & sum.ovf & sat_en);
    c_mul: cover property (wr & (address_i == ASD_OFS_MULU));
    c_store: cover property (wr & (address_i == ASD_OFS_STORE));
endmodule

// ==== asd_datapath_bench.sv ====
// Self-checking bench for the shift and overflow datapath
`timescale 1ns/1ps
module asd_datapath_bench import asd_pkg::*;;
    logic sys_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic read_i = 1'b0;
    logic write_i = 1'b0;
    logic [5:0] address_i = 6'h00;
    logic [31:0] writedata_i = 32'h0;
    logic [31:0] readdata_o;
    logic waitrequest_o;
    logic [15:0] data_write_bus_o;
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'h86a6faf3;
    int fail_count = 0;
    int check_count = 0;
    logic [31:0] r, p, e, s;
    logic [15:0] d, h;
    logic [4:0] k;

    always #25 sys_clk_i = ~sys_clk_i;

    asd_datapath dut (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .address_i(address_i),
        .read_i(read_i),
        .write_i(write_i),
        .writedata_i(writedata_i),
        .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o),
        .data_write_bus_o(data_write_bus_o)
    );

    // ********************************
    // Helpers
    // ********************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wrap_up;
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task bus(input logic w, input logic [5:0] a, input logic [31:0] v);
        int n;
        @(posedge sys_clk_i);
        address_i <= a;
        writedata_i <= v;
        write_i <= w;
        read_i <= ~w;
        n = 0;
        do
        begin
            @(posedge sys_clk_i);
            n++;
        end
        while (waitrequest_o !== 1'b0 && n < 20);
        if (n >= 20)
        begin
            fail_count++;
            wrap_up();
        end
        write_i <= 1'b0;
        read_i <= 1'b0;
    endtask

    task wr(input logic [5:0] a, input logic [31:0] v);
        bus(1'b1, a, v);
    endtask

    task rd(input logic [5:0] a, input logic [31:0] v);
        exp_q.push_back(v);
        bus(1'b0, a, 32'h0);
    endtask

    // Read monitor pairs each answer with the oldest note
    always @(posedge sys_clk_i)
        if (read_i === 1'b1 && waitrequest_o === 1'b0)
        begin
            if (exp_q.size() == 0)
                fail_count++;
            else
                chk(readdata_o, exp_q.pop_front());
        end

    // ********************************
    // Scenarios
    // ********************************
    initial
    begin
        repeat (4) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        rd(ASD_OFS_STA, 32'h0);
        rd(ASD_OFS_STB, 32'h400);
        r = rnd();
        wr(ASD_OFS_STB, {16'h0, r[15:0]});
        rd(ASD_OFS_STB, {16'h0, r[15:0]});
        wr(ASD_OFS_STA, {16'h0, r[31:16] & 16'hefff});
        rd(ASD_OFS_STA, {16'h0, r[31:16] & 16'hefff});
        rd(6'h3c, 32'h0);
        // Request held while the clock enable is low must wait
        @(posedge sys_clk_i);
        ce_i <= 1'b0;
        fork
            wr(ASD_OFS_STA, 32'h800);
            begin
                repeat (4) @(posedge sys_clk_i);
                chk({31'h0, waitrequest_o}, 32'h1);
                ce_i <= 1'b1;
            end
        join
        rd(ASD_OFS_STA, 32'h800);
        $display("test status words done");
        for (int i = 0; i < 4; i++)
        begin
            r = rnd();
            wr(i[0] ? ASD_OFS_MULU : ASD_OFS_MULS, r);
            if (i[0])
                p = r[31:16] * r[15:0];
            else
                p = $signed(r[31:16]) * $signed(r[15:0]);
            rd(ASD_OFS_PRODUCT_RESULT_REGISTER, p);
            for (int m = 0; m < 4; m++)
            begin
                wr(ASD_OFS_STB, 32'h400 | m);
                case (m)
                    0: e = p;
                    1: e = p << 1;
                    2: e = p << 4;
                    default: e = $signed(p) >>> 6;
                endcase
                rd(ASD_OFS_PSH, e);
            end
            rd(ASD_OFS_PRODUCT_RESULT_REGISTER, p);
        end
        $display("test product done");
        for (int i = 0; i < 16; i++)
        begin
            r = rnd();
            wr(ASD_OFS_ACC, r);
            s = r << i[2:0];
            h = i[3] ? s[31:16] : s[15:0];
            wr(ASD_OFS_STORE, {28'h0, i[3], i[2:0]});
            chk({16'h0, data_write_bus_o}, {16'h0, h});
            rd(ASD_OFS_STORE, {16'h0, h});
        end
        $display("test store done");
        for (int i = 0; i < 4; i++)
        begin
            wr(ASD_OFS_STB, i[1] ? 32'h400 : 32'h0);
            wr(ASD_OFS_ACC, 32'h0);
            r = rnd();
            d = r[15:0] | 16'h8000;
            k = r[20:16] > 5'h10 ? 5'h10 : r[20:16];
            wr(ASD_OFS_ADDIN, {11'h0, r[20:16], d});
            e = i[1] ? {{16{d[15]}}, d} << k : {16'h0, d} << k;
            rd(ASD_OFS_ACC, e);
        end
        for (int i = 0; i < 2; i++)
        begin
            wr(ASD_OFS_STB, i[0] ? 32'h400 : 32'h0);
            wr(ASD_OFS_ACC, 32'h80000012);
            wr(ASD_OFS_ASH, 32'h1);
            rd(ASD_OFS_ACC, i[0] ? 32'hc0000009 : 32'h40000009);
            wr(ASD_OFS_ASH, 32'h0);
            rd(ASD_OFS_ACC, 32'h80000012);
        end
        $display("test shifters done");
        wr(ASD_OFS_STB, 32'h400);
        wr(ASD_OFS_STA, 32'h0);
        wr(ASD_OFS_ACC, ASD_ACC_MAX);
        wr(ASD_OFS_ADDIN, 32'h1);
        rd(ASD_OFS_ACC, ASD_ACC_MIN);
        rd(ASD_OFS_STA, 32'h1000);
        wr(ASD_OFS_STA, 32'h800);
        rd(ASD_OFS_STA, 32'h800);
        wr(ASD_OFS_ACC, ASD_ACC_MAX);
        wr(ASD_OFS_ADDIN, 32'h1);
        rd(ASD_OFS_ACC, ASD_ACC_MAX);
        rd(ASD_OFS_STA, 32'h1800);
        wr(ASD_OFS_STA, 32'h800);
        wr(ASD_OFS_ACC, ASD_ACC_MIN);
        wr(ASD_OFS_ADDIN, 32'hffff);
        rd(ASD_OFS_ACC, ASD_ACC_MIN);
        rd(ASD_OFS_STA, 32'h1800);
        wr(ASD_OFS_STA, 32'h0);
        wr(ASD_OFS_STB, 32'h0);
        wr(ASD_OFS_MULS, 32'h7fff7fff);
        wr(ASD_OFS_ACC, 32'h40000000);
        wr(ASD_OFS_ADDP, 32'h0);
        rd(ASD_OFS_ACC, 32'h7fff0001);
        rd(ASD_OFS_STA, 32'h0);
        wr(ASD_OFS_ADDP, 32'h0);
        rd(ASD_OFS_ACC, 32'hbffe0002);
        rd(ASD_OFS_STA, 32'h1000);
        $display("test overflow done");
        wrap_up();
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        fail_count++;
        wrap_up();
    end
endmodule
